// File: hdl/nspe_regs.svh
// Register offsets, field positions, command codes and timing counts for the erase/status host
`ifndef NSPE_REGS_SVH
`define NSPE_REGS_SVH

`define NSPE_OFS_CTRL        8'h00
`define NSPE_OFS_BLK0        8'h04
`define NSPE_OFS_BLK1        8'h08
`define NSPE_OFS_STAT        8'h0C
`define NSPE_OFS_RESULT      8'h10

`define NSPE_CMD_ERASE_SETUP 8'h60
`define NSPE_CMD_ERASE_CONF  8'hD0
`define NSPE_CMD_STATUS      8'h70
`define NSPE_CMD_PLANE_STAT  8'hF1
`define NSPE_CMD_READ        8'h00
`define NSPE_CMD_RESET       8'hFF
`define NSPE_STAT_RESET_VAL  8'hC0

`define NSPE_CTRL_GO_ERASE   0
`define NSPE_CTRL_TWO_PLANE  1
`define NSPE_CTRL_GO_STATUS  2
`define NSPE_CTRL_GO_PLANE   3
`define NSPE_CTRL_GO_RESET   4
`define NSPE_CTRL_GO_READ    5

`define NSPE_SB_FAIL         0
`define NSPE_SB_P0FAIL       1
`define NSPE_SB_P1FAIL       2
`define NSPE_SB_REWRITE      3
`define NSPE_SB_READY        6
`define NSPE_SB_UNPROT       7
`define NSPE_STAT_USED_MASK  8'hC9
`define NSPE_PLANE_USED_MASK 8'hCF

`define NSPE_PLANE_BIT       0  // Block number bit that lands on A18
`define NSPE_BLK_W           12

`define NSPE_T_STROBE_NS     25
`define NSPE_CLK_NS          8
`define NSPE_T_STROBE_CYC    ((`NSPE_T_STROBE_NS + `NSPE_CLK_NS - 1) / `NSPE_CLK_NS)

`endif

// File: hdl/nspe_pkg.sv
// Types shared by the erase/status host
package nspe_pkg;
  typedef enum logic [3:0] {
    NSPE_IDLE   = 4'b0000,
    NSPE_CMD    = 4'b0001,
    NSPE_ADDR   = 4'b0011,
    NSPE_NEXT   = 4'b0010,
    NSPE_CONF   = 4'b0110,
    NSPE_WAIT   = 4'b0111,
    NSPE_POLL   = 4'b0101,
    NSPE_DONE   = 4'b0100,
    NSPE_SCMD   = 4'b1100
  } nspe_state_e;

  typedef enum logic [1:0] {
    NSPE_PH_IDLE = 2'b00,
    NSPE_PH_LOW  = 2'b01,
    NSPE_PH_HIGH = 2'b11
  } nspe_phase_e;
endpackage

// File: hdl/nspe_pin_cycle.sv
// One timed strobe cycle on the flash port: command, address, or status read
`timescale 1ns/1ps
`default_nettype none
`include "nspe_regs.svh"
module nspe_pin_cycle
  import nspe_pkg::*;
#(
  parameter int STROBE_CYC = `NSPE_T_STROBE_CYC
) (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       start,
  input  wire logic       is_read,
  input  wire logic       is_addr,
  input  wire logic [7:0] wdata,
  input  wire logic [7:0] io_in,
  output logic            busy,
  output logic            done,
  output logic [7:0]      rdata,
  output logic            cle,
  output logic            ale,
  output logic            write_strobe_n,
  output logic            read_strobe_n,
  output logic [7:0]      io_out,
  output logic            io_oe
);
  nspe_phase_e phase, next_phase;
  logic [7:0]  cnt, next_cnt;
  logic        rd, next_rd;
  logic        next_done;
  logic [7:0]  next_rdata;
  logic        next_cle, next_ale, next_we_n, next_re_n, next_oe;
  logic [7:0]  next_io_out;

  localparam logic [7:0] LAST = 8'(STROBE_CYC - 1);

  always_comb begin
    next_phase  = phase;
    next_cnt    = cnt;
    next_rd     = rd;
    next_done   = 1'b0;
    next_rdata  = rdata;
    next_cle    = cle;
    next_ale    = ale;
    next_we_n   = write_strobe_n;
    next_re_n   = read_strobe_n;
    next_oe     = io_oe;
    next_io_out = io_out;
    unique case (phase)
      NSPE_PH_IDLE: begin
        if (start) begin
          next_phase  = NSPE_PH_LOW;
          next_cnt    = 8'h00;
          next_rd     = is_read;
          next_cle    = !is_read && !is_addr;
          next_ale    = !is_read && is_addr;
          next_we_n   = is_read;
          next_re_n   = !is_read;
          next_oe     = !is_read;
          next_io_out = wdata;
        end
      end
      NSPE_PH_LOW: begin
        next_cnt = cnt + 8'h01;
        if (cnt == LAST) begin
          next_phase = NSPE_PH_HIGH;
          next_cnt   = 8'h00;
          next_we_n  = 1'b1;
          next_re_n  = 1'b1;
          if (rd) begin
            next_rdata = io_in; // Sampled at the end of the low phase
          end
        end
      end
      NSPE_PH_HIGH: begin
        next_cnt = cnt + 8'h01;
        if (cnt == LAST) begin
          next_phase = NSPE_PH_IDLE;
          next_done  = 1'b1;
          next_cle   = 1'b0;
          next_ale   = 1'b0;
          next_oe    = 1'b0;
        end
      end
      default: next_phase = NSPE_PH_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase          <= NSPE_PH_IDLE;
      cnt            <= 8'h00;
      rd             <= 1'b0;
      done           <= 1'b0;
      rdata          <= 8'h00;
      cle            <= 1'b0;
      ale            <= 1'b0;
      write_strobe_n <= 1'b1;
      read_strobe_n  <= 1'b1;
      io_out         <= 8'h00;
      io_oe          <= 1'b0;
    end else begin
      phase          <= next_phase;
      cnt            <= next_cnt;
      rd             <= next_rd;
      done           <= next_done;
      rdata          <= next_rdata;
      cle            <= next_cle;
      ale            <= next_ale;
      write_strobe_n <= next_we_n;
      read_strobe_n  <= next_re_n;
      io_out         <= next_io_out;
      io_oe          <= next_oe;
    end
  end

  assign busy = (phase != NSPE_PH_IDLE);
endmodule
`default_nettype wire

// File: hdl/nspe_host.sv
// Flash controller for two-plane block erase and status polling, AXI4-Lite command port
`timescale 1ns/1ps
`default_nettype none
`include "nspe_regs.svh"
module nspe_host
  import nspe_pkg::*;
#(
  parameter int STROBE_CYC = `NSPE_T_STROBE_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             chip_enable_n,
  output logic             cle,
  output logic             ale,
  output logic             write_strobe_n,
  output logic             read_strobe_n,
  output logic [7:0]       io_out,
  output logic             io_oe,
  input  wire logic [7:0]  io_in,
  input  wire logic        ready_busy
);
  function automatic logic [7:0] blk_addr_byte(input logic [`NSPE_BLK_W-1:0] blk,
                                                input logic [1:0] idx);
    // Row cycles carry A12..A29; block sits at A18 upward, page bits A12..A17 zero
    logic [23:0] row;
    row = {6'h00, blk, 6'h00};
    blk_addr_byte = row[idx*8 +: 8];
  endfunction

  // Register state
  logic [`NSPE_BLK_W-1:0] blk0, blk1, next_blk0, next_blk1;
  logic        two_plane, next_two_plane;
  logic [7:0]  last_stat, next_last_stat;
  logic        op_done, next_op_done, erase_fail, next_erase_fail;
  logic        aw_hold, next_aw_hold, w_hold, next_w_hold;
  logic [7:0]  aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic        next_bvalid, next_rvalid;
  logic [31:0] next_rdata;
  logic [5:0]  go, next_go;
  logic        rst_pend, next_rst_pend;

  // Sequencer state
  nspe_state_e st, next_st;
  logic [1:0]  acnt, next_acnt;
  logic        plane, next_plane;
  logic [7:0]  cur_cmd, next_cur_cmd;
  logic        cyc_start, cyc_read, cyc_addr, cyc_busy, cyc_done;
  logic [7:0]  cyc_wdata, cyc_rdata;

  nspe_pin_cycle #(.STROBE_CYC(STROBE_CYC)) u_cyc (
    .aclk(aclk), .aresetn(aresetn), .start(cyc_start), .is_read(cyc_read),
    .is_addr(cyc_addr), .wdata(cyc_wdata), .io_in(io_in), .busy(cyc_busy),
    .done(cyc_done), .rdata(cyc_rdata), .cle(cle), .ale(ale),
    .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
    .io_out(io_out), .io_oe(io_oe));

  wire logic wr_fire = aw_hold && w_hold && !s_axi_bvalid;
  wire logic idle    = (st == NSPE_IDLE);

  // AXI slave and registers
  always_comb begin
    next_aw_hold = aw_hold;
    next_w_hold  = w_hold;
    next_aw_addr = aw_addr;
    next_w_data  = w_data;
    next_bvalid  = s_axi_bvalid && !s_axi_bready;
    next_rvalid  = s_axi_rvalid && !s_axi_rready;
    next_rdata   = s_axi_rdata;
    next_blk0    = blk0;
    next_blk1    = blk1;
    next_two_plane = two_plane;
    next_go      = 6'h00;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_hold = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_hold = 1'b1;
      next_w_data = s_axi_wdata;
    end
    if (wr_fire) begin
      next_aw_hold = 1'b0;
      next_w_hold  = 1'b0;
      next_bvalid  = 1'b1;
      if (aw_addr == `NSPE_OFS_CTRL && w_data[0] && idle) begin
        next_go        = w_data[5:0];
        next_two_plane = w_data[`NSPE_CTRL_TWO_PLANE];
      end else if (aw_addr == `NSPE_OFS_CTRL && w_data[`NSPE_CTRL_GO_RESET]) begin
        next_go = 6'h10; // Reset is honoured even while busy
      end else if (aw_addr == `NSPE_OFS_CTRL && idle) begin
        next_go = w_data[5:0];
      end else if (aw_addr == `NSPE_OFS_BLK0 && s_axi_wstrb[0]) begin
        next_blk0 = w_data[`NSPE_BLK_W-1:0];
      end else if (aw_addr == `NSPE_OFS_BLK1 && s_axi_wstrb[0]) begin
        next_blk1 = w_data[`NSPE_BLK_W-1:0];
      end
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      unique case (s_axi_araddr)
        `NSPE_OFS_CTRL:   next_rdata = {30'h0, two_plane, 1'b0};
        `NSPE_OFS_BLK0:   next_rdata = {20'h0, blk0};
        `NSPE_OFS_BLK1:   next_rdata = {20'h0, blk1};
        `NSPE_OFS_STAT:   next_rdata = {28'h0, ready_busy, erase_fail, op_done, !idle};
        `NSPE_OFS_RESULT: next_rdata = {24'h0, last_stat};
        default:          next_rdata = 32'h0;
      endcase
    end
  end

  // Erase and status sequencer
  always_comb begin
    next_st        = st;
    next_acnt      = acnt;
    next_plane     = plane;
    next_cur_cmd   = cur_cmd;
    next_last_stat = last_stat;
    next_op_done   = op_done;
    next_erase_fail = erase_fail;
    next_rst_pend   = 1'b0;
    cyc_start = 1'b0;
    cyc_read  = 1'b0;
    cyc_addr  = 1'b0;
    cyc_wdata = cur_cmd;
    unique case (st)
      NSPE_IDLE: begin
        // No program code is ever sent, so the per-page program limit cannot be broken
        if (go[`NSPE_CTRL_GO_RESET]) begin
          next_cur_cmd = `NSPE_CMD_RESET; next_st = NSPE_SCMD;
        end else if (go[`NSPE_CTRL_GO_ERASE]) begin
          next_plane = 1'b0; next_st = NSPE_CMD; next_op_done = 1'b0;
        end else if (go[`NSPE_CTRL_GO_STATUS]) begin
          next_cur_cmd = `NSPE_CMD_STATUS; next_st = NSPE_SCMD;
        end else if (go[`NSPE_CTRL_GO_PLANE]) begin
          next_cur_cmd = `NSPE_CMD_PLANE_STAT; next_st = NSPE_SCMD;
        end else if (go[`NSPE_CTRL_GO_READ]) begin
          next_cur_cmd = `NSPE_CMD_READ; next_st = NSPE_SCMD; // Leaves status mode
        end
      end
      NSPE_SCMD: begin
        cyc_start = !cyc_busy && !cyc_done;
        cyc_wdata = cur_cmd;
        if (cyc_done) begin
          next_st = (cur_cmd == `NSPE_CMD_STATUS || cur_cmd == `NSPE_CMD_PLANE_STAT)
                    ? NSPE_POLL : NSPE_IDLE;
        end
      end
      NSPE_CMD: begin
        cyc_start = !cyc_busy && !cyc_done;
        cyc_wdata = `NSPE_CMD_ERASE_SETUP;
        if (cyc_done) begin
          next_st = NSPE_ADDR; next_acnt = 2'd0;
        end
      end
      NSPE_ADDR: begin
        cyc_start = !cyc_busy && !cyc_done;
        cyc_addr  = 1'b1;
        cyc_wdata = blk_addr_byte(plane ? blk1 : blk0, acnt);
        if (cyc_done) begin
          next_acnt = acnt + 2'd1;
          if (acnt == 2'd2) next_st = NSPE_NEXT;
        end
      end
      NSPE_NEXT: begin
        // Second group only once, and only for a different plane
        if (two_plane && !plane && (blk0[`NSPE_PLANE_BIT] != blk1[`NSPE_PLANE_BIT])) begin
          next_plane = 1'b1; next_st = NSPE_CMD;
        end else begin
          next_st = NSPE_CONF;
        end
      end
      NSPE_CONF: begin
        cyc_start = !cyc_busy && !cyc_done;
        cyc_wdata = `NSPE_CMD_ERASE_CONF;
        if (cyc_done) next_st = NSPE_WAIT;
      end
      NSPE_WAIT: begin
        // Only ready/busy is watched here; no command but a requested reset is sent while busy
        if (ready_busy) begin
          next_cur_cmd = `NSPE_CMD_PLANE_STAT; next_st = NSPE_SCMD;
          next_op_done = 1'b1;
        end
      end
      NSPE_POLL: begin
        cyc_start = !cyc_busy && !cyc_done;
        cyc_read  = 1'b1;
        if (cyc_done) begin
          next_last_stat = cyc_rdata & ((cur_cmd == `NSPE_CMD_PLANE_STAT)
                           ? `NSPE_PLANE_USED_MASK : `NSPE_STAT_USED_MASK);
          // Either plane failing counts as overall fail
          if (cur_cmd == `NSPE_CMD_PLANE_STAT) begin
            next_erase_fail = cyc_rdata[`NSPE_SB_FAIL] | cyc_rdata[`NSPE_SB_P0FAIL]
                              | cyc_rdata[`NSPE_SB_P1FAIL];
          end else begin
            next_erase_fail = cyc_rdata[`NSPE_SB_FAIL];
          end
          next_st = NSPE_DONE;
        end
      end
      NSPE_DONE: next_st = NSPE_IDLE;
      default:   next_st = NSPE_IDLE;
    endcase
    // A reset that arrives mid-strobe waits for the strobe, else the one-cycle go would be lost
    if ((go[`NSPE_CTRL_GO_RESET] || rst_pend) && st != NSPE_IDLE) begin
      if (cyc_busy) begin
        next_rst_pend = 1'b1;
      end else begin
        next_cur_cmd = `NSPE_CMD_RESET; next_st = NSPE_SCMD;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold <= 1'b0; w_hold <= 1'b0; aw_addr <= 8'h00; w_data <= 32'h0;
      s_axi_bvalid <= 1'b0; s_axi_rvalid <= 1'b0; s_axi_rdata <= 32'h0;
      blk0 <= '0; blk1 <= '0; two_plane <= 1'b0; go <= 6'h00;
      st <= NSPE_IDLE; acnt <= 2'd0; plane <= 1'b0; cur_cmd <= 8'h00;
      last_stat <= 8'h00; op_done <= 1'b0; erase_fail <= 1'b0;
      rst_pend <= 1'b0;
      s_axi_awready <= 1'b0; s_axi_wready <= 1'b0; s_axi_arready <= 1'b0;
      chip_enable_n <= 1'b1;
    end else begin
      aw_hold <= next_aw_hold; w_hold <= next_w_hold;
      aw_addr <= next_aw_addr; w_data <= next_w_data;
      s_axi_bvalid <= next_bvalid; s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      blk0 <= next_blk0; blk1 <= next_blk1; two_plane <= next_two_plane;
      go <= next_go;
      st <= next_st; acnt <= next_acnt; plane <= next_plane; cur_cmd <= next_cur_cmd;
      last_stat <= next_last_stat; op_done <= next_op_done; erase_fail <= next_erase_fail;
      rst_pend <= next_rst_pend;
      s_axi_awready <= !next_aw_hold && !s_axi_awready;
      s_axi_wready  <= !next_w_hold && !s_axi_wready;
      s_axi_arready <= !next_rvalid && !s_axi_arready;
      chip_enable_n <= 1'b0; // Single device, kept selected
    end
  end

  assign s_axi_bresp = 2'b00;
  assign s_axi_rresp = 2'b00;
endmodule
`default_nettype wire

// File: test/nspe_host_checker.sv
// Concurrent checks on the host's AXI4-Lite side and flash pins
`timescale 1ns/1ps
`default_nettype none
module nspe_host_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        chip_enable_n,
  input wire logic        cle,
  input wire logic        ale,
  input wire logic        write_strobe_n,
  input wire logic        read_strobe_n,
  input wire logic [7:0]  io_out,
  input wire logic        ready_busy
);
  logic       we_q, next_we_q, plane0, next_plane0, cmd_rise, adr_rise;
  logic [7:0] last_cmd, next_last_cmd, ar_q, next_ar_q;
  logic [1:0] n_setup, next_n_setup;
  logic [2:0] n_addr, next_n_addr;
  assign cmd_rise = write_strobe_n && !we_q && cle;
  assign adr_rise = write_strobe_n && !we_q && ale;
  // Setups and address bytes are counted per erase so the confirm can be judged
  always_comb begin
    next_we_q = write_strobe_n;
    next_last_cmd = cmd_rise ? io_out : last_cmd;
    next_ar_q = (s_axi_arvalid && s_axi_arready) ? s_axi_araddr : ar_q;
    next_n_setup = n_setup;
    next_n_addr = n_addr;
    next_plane0 = plane0;
    if (cmd_rise && io_out == 8'h60) begin
      next_n_setup = (last_cmd == 8'h60) ? n_setup + 2'h1 : 2'h1;
      next_n_addr = (last_cmd == 8'h60) ? n_addr : 3'h0;
    end
    if (adr_rise) next_n_addr = n_addr + 3'h1;
    if (adr_rise && n_addr == 3'h0) next_plane0 = io_out[6];
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      we_q <= 1'h1;
      last_cmd <= 8'h00;
      ar_q <= 8'h00;
      n_setup <= 2'h0;
      n_addr <= 3'h0;
      plane0 <= 1'h0;
    end else begin
      we_q <= next_we_q;
      last_cmd <= next_last_cmd;
      ar_q <= next_ar_q;
      n_setup <= next_n_setup;
      n_addr <= next_n_addr;
      plane0 <= next_plane0;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not one cycle after address");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped or changed before taken");
  a_write_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped before taken");
  a_erase_groups: assert property (cmd_rise && io_out == 8'hD0 |->
    (n_setup == 2'h1 && n_addr == 3'h3) || (n_setup == 2'h2 && n_addr == 3'h6))
    else $error("erase confirm after a wrong address group count");
  a_planes_differ: assert property (adr_rise && n_addr == 3'h3 |-> io_out[6] != plane0)
    else $error("second erase block in the same plane");
  a_busy_commands: assert property (cmd_rise && !ready_busy |-> io_out inside {8'h70, 8'hFF})
    else $error("command other than status or reset while busy");
  a_read_after_status: assert property ($fell(read_strobe_n) |->
    !chip_enable_n && last_cmd inside {8'h70, 8'hF1, 8'hF2})
    else $error("read cycle outside status mode");
  a_result_masked: assert property (s_axi_rvalid && ar_q == 8'h10 |->
    (s_axi_rdata & ~32'h000000CF) == 32'h0)
    else $error("unused status bits reach the result register");
  cover property (adr_rise && n_addr == 3'h3);
  cover property (cmd_rise && !ready_busy);
  cover property (s_axi_rvalid && ar_q == 8'h10 && s_axi_rdata[0]);
endmodule
`default_nettype wire

// File: test/nspe_flash_model.sv
// Behavioural flash die: erase queue, busy timing and status bytes
`timescale 1ns/1ps
`default_nettype none
module nspe_flash_model (
  input  wire logic        aclk,
  input  wire logic        chip_enable_n,
  input  wire logic        cle,
  input  wire logic        ale,
  input  wire logic        write_strobe_n,
  input  wire logic        read_strobe_n,
  input  wire logic [7:0]  io_out,
  input  wire logic        io_oe,
  input  wire logic [1:0]  fail_plane,
  input  wire logic [15:0] busy_cyc,
  output logic      [7:0]  io_in,
  output logic             ready_busy = 1'h1
);
  logic        we_q = 1'h1, stat_mode = 1'h0, plane_mode = 1'h0, we_rise;
  logic [2:0]  fails = 3'h0;
  logic [1:0]  queued = 2'h0, n_adr = 2'h0;
  logic [15:0] cnt = 16'h0000;
  logic [7:0]  last = 8'h00, stat;
  assign we_rise = write_strobe_n && !we_q && !chip_enable_n && io_oe;
  always @(posedge aclk) begin
    we_q <= write_strobe_n;
    last <= io_in;
    if (we_rise && cle) begin
      stat_mode  <= io_out inside {8'h70, 8'hF1, 8'hF2};
      plane_mode <= io_out inside {8'hF1, 8'hF2};
      if (io_out == 8'h60) n_adr <= 2'h0;
      if (io_out == 8'hD0 && queued != 2'h0) begin
        ready_busy <= 1'h0;
        cnt        <= busy_cyc;
      end
      if (io_out == 8'hFF) begin
        queued     <= 2'h0;
        fails      <= 3'h0;
        ready_busy <= 1'h0;
        cnt        <= 16'h0003;
      end
    end else if (we_rise && ale) begin
      // Only bit 6 of the first row byte, block bit 0, picks the plane
      if (n_adr == 2'h0) queued[io_out[6]] <= 1'h1;
      n_adr <= n_adr + 2'h1;
    end else if (!ready_busy) begin
      cnt <= cnt - 16'h0001;
      if (cnt <= 16'h0001) begin
        ready_busy <= 1'h1;
        fails      <= {queued & fail_plane, |(queued & fail_plane)};
        queued     <= 2'h0;
      end
    end
  end
  // No page read is modelled, so no ECC result byte is ever shown
  // Unused bits read as ones so a host that forgets to mask them is caught
  always_comb begin
    if (plane_mode) stat = {1'h1, ready_busy, 3'h6, fails};
    else stat = {1'h1, ready_busy, 3'h6, 2'h3, fails[0]};
  end
  // Live status while selected; a released bus toggles instead of holding
  assign io_in = (!read_strobe_n && !chip_enable_n && stat_mode) ? stat : ~last;
endmodule
`default_nettype wire

// File: test/nspe_host_tb.sv
// Self-checking bench for the erase/status host against a behavioural flash
`timescale 1ns/1ps
`default_nettype none
`include "nspe_regs.svh"
module nspe_host_tb;
  localparam int STROBE_CYC = 4;
  // Expected plane status: ready, unprotected, erased planes' fail bits and their OR
  typedef struct {logic two; logic [11:0] b0; logic [11:0] b1; logic [1:0] fl;
    logic [15:0] busy; logic [7:0] exp;} nspe_row_s;
  nspe_row_s   rows [5] = '{'{1'h0, 12'h000, 12'h001, 2'h0, 16'h0005, 8'hC0},
    '{1'h1, 12'h002, 12'hFFF, 2'h2, 16'h012C, 8'hC5},
    '{1'h1, 12'h7FE, 12'h801, 2'h1, 16'h0040, 8'hC3},
    '{1'h1, 12'h004, 12'h044, 2'h2, 16'h0008, 8'hC0},
    '{1'h0, 12'hFFF, 12'h002, 2'h3, 16'h0002, 8'hC5}};
  logic        aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, io_out, io_in;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, r;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [1:0]  s_axi_bresp, s_axi_rresp, fail_plane = 2'h0;
  logic [15:0] busy_cyc = 16'h0001;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        chip_enable_n, cle, ale, write_strobe_n, read_strobe_n, io_oe, ready_busy;
  int          fail_count = 0;
  int          n_checks = 0;
  nspe_host #(.STROBE_CYC(STROBE_CYC)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .chip_enable_n, .cle, .ale, .write_strobe_n,
    .read_strobe_n, .io_out, .io_oe, .io_in, .ready_busy);
  nspe_flash_model flash (.aclk, .chip_enable_n, .cle, .ale, .write_strobe_n, .read_strobe_n,
    .io_out, .io_oe, .fail_plane, .busy_cyc, .io_in, .ready_busy);
  initial forever #4 aclk = ~aclk;
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    logic aw_done = 1'h0, w_done = 1'h0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (s_axi_awready && s_axi_awvalid) aw_done = 1'h1;
      if (s_axi_wready && s_axi_wvalid) w_done = 1'h1;
      if (aw_done) s_axi_awvalid <= 1'h0;
      if (w_done) s_axi_wvalid <= 1'h0;
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    check("write response", 32'h0, {30'h0, s_axi_bresp});
  endtask
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    check("read response", 32'h0, {30'h0, s_axi_rresp});
    s_axi_rready <= 1'h0;
  endtask
  task automatic wait_idle();
    r = 32'h1;
    repeat (4) @(posedge aclk);
    while (r[0] !== 1'h0) axi_read(`NSPE_OFS_STAT, r);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge aclk);
    fail_count++;
    $display("mismatch watchdog expected finish seen hang");
    test_done();
  end
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    for (int i = 0; i < 5; i++) begin
      fail_plane <= rows[i].fl;
      busy_cyc <= rows[i].busy;
      axi_write(`NSPE_OFS_BLK0, {20'h0, rows[i].b0});
      axi_write(`NSPE_OFS_BLK1, {20'h0, rows[i].b1});
      axi_write(`NSPE_OFS_CTRL, {30'h0, rows[i].two, 1'h1});
      wait_idle();
      axi_read(`NSPE_OFS_RESULT, r);
      check("result", {24'h0, rows[i].exp}, r);
      axi_read(`NSPE_OFS_STAT, r);
      check("fail flag", {31'h0, rows[i].exp[0]}, {31'h0, r[2]});
      $display("test erase row %0d done", i);
    end
    // Reset command lands in the middle of a slow erase
    fail_plane <= 2'h3;
    busy_cyc <= 16'h0300;
    axi_write(`NSPE_OFS_CTRL, 32'h1);
    r = 32'h8;
    while (r[3] !== 1'h0) axi_read(`NSPE_OFS_STAT, r);
    axi_write(`NSPE_OFS_CTRL, 32'h10);
    wait_idle();
    axi_write(`NSPE_OFS_CTRL, 32'h8);
    wait_idle();
    axi_read(`NSPE_OFS_RESULT, r);
    check("plane status after abort", 32'hC0, r);
    axi_write(`NSPE_OFS_CTRL, 32'h4);
    wait_idle();
    axi_read(`NSPE_OFS_RESULT, r);
    check("basic status masked", 32'hC0, r);
    axi_write(`NSPE_OFS_CTRL, 32'h20);
    wait_idle();
    $display("test reset abort done");
    axi_write(8'h24, 32'hFFFF_FFFF);
    axi_read(8'h24, r);
    check("unmapped read", 32'h0, r);
    axi_read(`NSPE_OFS_BLK0, r);
    check("block 0 kept", 32'hFFF, r);
    aresetn <= 1'h0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    axi_read(`NSPE_OFS_STAT, r);
    check("status after reset", 32'h8, r);
    axi_read(`NSPE_OFS_BLK0, r);
    check("block 0 after reset", 32'h0, r);
    $display("test registers and reset done");
    test_done();
  end
endmodule
bind nspe_host nspe_host_checker u_chk (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .chip_enable_n, .cle, .ale, .write_strobe_n, .read_strobe_n, .io_out, .ready_busy);
`default_nettype wire
